// *** hw/emu_debug_pkg.sv ***
// constants and carrier types for the emulator-mode and trace block
package emu_debug_pkg;
  // register byte offsets
  localparam logic [3:0] REG_CFG_OFS = 4'h0;
  localparam logic [3:0] REG_STAT_OFS = 4'h4;
  // configuration field positions
  localparam int CFG_EMU_POS = 0;
  localparam int CFG_TRC_POS = 1;
  localparam int CFG_MAP_POS = 2;
  localparam int CFG_SHOW_RD_POS = 3;
  localparam int CFG_SHOW_WR_POS = 4;
  localparam int CFG_TGT_POS = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK = 32'h0000_031F;
  // status field positions
  localparam int STAT_EMU_POS = 0;
  localparam int STAT_GRANT_POS = 1;
  localparam int STAT_STALL_POS = 2;
  localparam int STAT_TRACE_POS = 3;
  localparam int STAT_FLAG_POS = 4;
  // status and marker nibbles
  localparam logic [3:0] PST_IDLE = 4'h0;
  localparam logic [3:0] PST_NORMAL = 4'h1;
  localparam logic [3:0] PST_TAKEN = 4'h5;
  localparam logic [3:0] PST_EXIT = 4'h7;
  localparam logic [3:0] PST_ENTRY = 4'hD;
  localparam logic [3:0] MK_BYTE = 4'h8;
  localparam logic [3:0] MK_WORD = 4'h9;
  localparam logic [3:0] MK_3BYTE = 4'hA;
  localparam logic [3:0] MK_LONG = 4'hB;
  // remapped address space attributes
  localparam logic [1:0] TT_REMAP = 2'h2;
  localparam logic [2:0] TM_REMAP_DATA = 3'h5;
  localparam logic [2:0] TM_REMAP_FETCH = 3'h6;
  // emulator flag inside the top longword of a stack frame
  localparam int FS_EMU_POS = 17;
  // cycles the entry code stands on the status output
  localparam logic [2:0] ENTRY_HOLD_CYCLES = 3'h3;
  // operand sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  typedef struct packed {
    logic [1:0] tt;
    logic [2:0] tm;
  } bus_attr_s;

  typedef struct packed {
    logic cof;
    logic cond;
    logic taken;
    logic tgt_valid;
    logic [31:0] tgt_addr;
    logic rd_valid;
    logic [1:0] rd_size;
    logic [31:0] rd_data;
    logic wr_valid;
    logic [1:0] wr_size;
    logic [31:0] wr_data;
  } trace_rec_s;
endpackage : emu_debug_pkg

// *** hw/emu_debug_core.sv ***
// emulator mode control, debug bus sharing and status/trace nibble stream
// Summary of operation
// - force-emulation bit is looked at only when reset exception processing starts.
// - debug interrupt exception start always enters emulator mode.
// - trace exception start enters emulator mode when trace-emulation bit set.
// - interrupts still serviced in emulator mode; frame fault flag marks it.
// - remap bit with emulator mode disables caching and on-chip SRAM.
// - remapped accesses use transfer type 2, modifier 5 or 6.
// - return from exception leaves emulator mode.
// - status output shows 0xD on entry and 0x7 on exit; mid data nibbles 0x7 is dropped and 0xD shows only in hold cycles left.
// - debug commands run concurrently except register accesses while core runs.
// - memory debug command: stall fetch, let bus finish, then grant.
// - core takes the bus back after the debug bus cycle.
// - instruction traces status 1 plus optional operand records per configuration.
// - operand record marker 0x8, 0x9 or 0xB precedes the data nibbles.
// - configuration selects operands for reads, writes or both.
// - config bits 9:8 select 2, 3 or 4 target bytes, markers 9/A/B.
// - conditional branch 5 taken, 1 not taken; unconditional always 5.
// - subroutine branch shows 5 then optional destination record of 2, 3 or 4 bytes per config bits 9:8.
// - bit operations on memory show 1 with byte source and destination.
// - operand record size follows the operation size.
// - long read-modify-write shows 1, four-byte source and destination records.
// - entry code 0xD is held for several cycles.
// - emulator flag sits at bit 17 of the frame's top longword.
// - return reloads the stacked flag and re-enters emulator mode if set.
`timescale 1ns/1ps
`default_nettype none
module emu_debug_core #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // register bus
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // core exception events
  input wire logic RESET_PROC_START,
  input wire logic DEBUG_EXC_START,
  input wire logic TRACE_EXC_START,
  input wire logic OTHER_EXC_START,
  input wire logic RTE_EXEC,
  input wire logic RTE_STACKED_FLAG,
  output logic EMU_MODE,
  output logic [31:0] FRAME_FAULT_WORD,
  // memory access attributes
  input wire logic ACC_IS_FETCH,
  input wire emu_debug_pkg::bus_attr_s CORE_ATTR,
  output var emu_debug_pkg::bus_attr_s MEM_ATTR,
  output logic CACHE_SRAM_DISABLE,
  // debug command and bus sharing
  input wire logic CMD_VALID,
  input wire logic CMD_REG_ACCESS,
  input wire logic CORE_HALTED,
  output logic CMD_ACCEPT,
  output logic CMD_REFUSE,
  input wire logic DBG_BUS_REQ,
  input wire logic CORE_BUS_IDLE,
  input wire logic DBG_BUS_DONE,
  output logic FETCH_STALL,
  output logic DBG_BUS_GRANT,
  // trace stream
  input wire logic TRACE_VALID,
  input wire emu_debug_pkg::trace_rec_s TRACE_REC,
  output logic TRACE_READY,
  output logic [3:0] STATUS_TRACE
);
  typedef enum {ARB_CORE, ARB_DRAIN, ARB_DEBUG} arb_e;
  typedef enum {TR_IDLE, TR_STAT, TR_MARK, TR_DATA} tr_e;

  // segment 0 target, 1 read operand, 2 write operand
  function automatic logic seg_on(input emu_debug_pkg::trace_rec_s r,
                                  input logic [31:0] c, input logic [1:0] s);
    logic on;
    on = 1'b0;
    unique case (s)
      2'h0: on = r.cof && r.taken && r.tgt_valid && (c[emu_debug_pkg::CFG_TGT_POS +: 2] != 2'h0);
      2'h1: on = r.rd_valid && c[emu_debug_pkg::CFG_SHOW_RD_POS];
      2'h2: on = r.wr_valid && c[emu_debug_pkg::CFG_SHOW_WR_POS];
      default: on = 1'b0;
    endcase
    return on;
  endfunction : seg_on

  function automatic logic [3:0] size_marker(input logic [1:0] sz);
    logic [3:0] m;
    m = emu_debug_pkg::MK_LONG;
    if (sz == emu_debug_pkg::SZ_BYTE) begin
      m = emu_debug_pkg::MK_BYTE;
    end else if (sz == emu_debug_pkg::SZ_WORD) begin
      m = emu_debug_pkg::MK_WORD;
    end
    return m;
  endfunction : size_marker

  // data left aligned so the top nibble leaves first
  function automatic logic [31:0] size_align(input logic [1:0] sz, input logic [31:0] d);
    logic [31:0] a;
    a = d;
    if (sz == emu_debug_pkg::SZ_BYTE) begin
      a = {d[7:0], 24'h00_0000};
    end else if (sz == emu_debug_pkg::SZ_WORD) begin
      a = {d[15:0], 16'h0000};
    end
    return a;
  endfunction : size_align

  function automatic logic [3:0] size_nibbles(input logic [1:0] sz);
    logic [3:0] n;
    n = 4'h8;
    if (sz == emu_debug_pkg::SZ_BYTE) begin
      n = 4'h2;
    end else if (sz == emu_debug_pkg::SZ_WORD) begin
      n = 4'h4;
    end
    return n;
  endfunction : size_nibbles

  // register bus state
  logic [31:0] cfg_reg, cfg_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  // mode, status output and trace state
  logic emu_reg, emu_next;
  logic flag_reg, flag_next;
  logic [2:0] hold_reg, hold_next;
  logic exit_reg, exit_next;
  logic [3:0] pst_reg, pst_next;
  tr_e tr_reg, tr_next;
  emu_debug_pkg::trace_rec_s rec_reg, rec_next;
  logic [1:0] seg_reg, seg_next;
  logic [3:0] nib_reg, nib_next;
  logic [31:0] shift_reg, shift_next;
  logic ready_reg, ready_next;
  emu_debug_pkg::bus_attr_s attr_reg, attr_next;
  logic cdis_reg, cdis_next;
  // arbitration state
  arb_e arb_reg, arb_next;
  logic [1:0] share_reg, share_next;
  logic acc_reg, acc_next;
  logic ref_reg, ref_next;

  logic remap;
  logic entry_evt;
  logic exit_evt;
  logic show_d;
  logic show_7;
  logic free;
  logic [1:0] tsel;
  logic [31:0] stat_word;

  assign remap = emu_reg && cfg_reg[emu_debug_pkg::CFG_MAP_POS];
  assign stat_word = {27'h000_0000, flag_reg, (tr_reg != TR_IDLE), (arb_reg != ARB_CORE),
                      (arb_reg == ARB_DEBUG), emu_reg};
  assign tsel = cfg_reg[emu_debug_pkg::CFG_TGT_POS +: 2];

  // register bus: one wait cycle, then answer
  always_comb begin
    cfg_next = cfg_reg;
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    if ((AVS_READ || AVS_WRITE) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = 32'h0000_0000;
      if (AVS_READ && AVS_ADDRESS == emu_debug_pkg::REG_CFG_OFS) begin
        rdata_next = cfg_reg;
      end else if (AVS_READ && AVS_ADDRESS == emu_debug_pkg::REG_STAT_OFS) begin
        rdata_next = stat_word;
      end
    end
    if (AVS_WRITE && !wait_reg && AVS_ADDRESS == emu_debug_pkg::REG_CFG_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (AVS_BYTEENABLE[b]) begin
          cfg_next[8*b +: 8] = AVS_WRITEDATA[8*b +: 8] & emu_debug_pkg::CFG_WMASK[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cfg_reg <= emu_debug_pkg::CFG_RESET;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // entry and exit of emulator mode
  assign entry_evt = DEBUG_EXC_START
                   || (TRACE_EXC_START && cfg_reg[emu_debug_pkg::CFG_TRC_POS])
                   || (RESET_PROC_START && cfg_reg[emu_debug_pkg::CFG_EMU_POS])
                   || (RTE_EXEC && RTE_STACKED_FLAG);
  assign exit_evt = RTE_EXEC && !RTE_STACKED_FLAG && emu_reg;
  assign show_d = entry_evt || (hold_reg != 3'h0);
  assign show_7 = (exit_evt || exit_reg) && !show_d;
  assign free = !show_d && !show_7;

  always_comb begin
    emu_next = emu_reg;
    flag_next = flag_reg;
    hold_next = (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
    exit_next = exit_reg;
    pst_next = emu_debug_pkg::PST_IDLE;
    tr_next = tr_reg;
    rec_next = rec_reg;
    seg_next = seg_reg;
    nib_next = nib_reg;
    shift_next = shift_reg;
    if (OTHER_EXC_START && !entry_evt) begin
      flag_next = emu_reg;
      emu_next = 1'b0;
    end
    if (entry_evt) begin
      emu_next = 1'b1;
      hold_next = emu_debug_pkg::ENTRY_HOLD_CYCLES - 3'h1;
    end else if (exit_evt) begin
      emu_next = 1'b0;
      exit_next = 1'b1;
    end
    if (show_d) begin
      pst_next = emu_debug_pkg::PST_ENTRY;
    end else if (show_7) begin
      pst_next = emu_debug_pkg::PST_EXIT;
      exit_next = 1'b0;
    end
    unique case (tr_reg)
      TR_IDLE: begin
        if (TRACE_VALID && ready_reg) begin
          rec_next = TRACE_REC;
          tr_next = TR_STAT;
        end
      end
      TR_STAT: begin
        if (free) begin
          pst_next = (rec_reg.cof && (!rec_reg.cond || rec_reg.taken)) ?
                     emu_debug_pkg::PST_TAKEN : emu_debug_pkg::PST_NORMAL;
          tr_next = TR_IDLE;
          for (int s = 2; s >= 0; s--) begin
            if (seg_on(rec_reg, cfg_reg, s[1:0])) begin
              seg_next = s[1:0];
              tr_next = TR_MARK;
            end
          end
        end
      end
      TR_MARK: begin
        if (free) begin
          tr_next = TR_DATA;
          unique case (seg_reg)
            2'h0: begin
              pst_next = (tsel == 2'h1) ? emu_debug_pkg::MK_WORD :
                         ((tsel == 2'h2) ? emu_debug_pkg::MK_3BYTE : emu_debug_pkg::MK_LONG);
              nib_next = (tsel == 2'h1) ? 4'h4 : ((tsel == 2'h2) ? 4'h6 : 4'h8);
              shift_next = (tsel == 2'h1) ? {rec_reg.tgt_addr[15:0], 16'h0000} :
                           ((tsel == 2'h2) ? {rec_reg.tgt_addr[23:0], 8'h00} : rec_reg.tgt_addr);
            end
            2'h1: begin
              pst_next = size_marker(rec_reg.rd_size);
              nib_next = size_nibbles(rec_reg.rd_size);
              shift_next = size_align(rec_reg.rd_size, rec_reg.rd_data);
            end
            default: begin
              pst_next = size_marker(rec_reg.wr_size);
              nib_next = size_nibbles(rec_reg.wr_size);
              shift_next = size_align(rec_reg.wr_size, rec_reg.wr_data);
            end
          endcase
        end
      end
      TR_DATA: begin
        // data nibbles run without gaps once the marker is out
        pst_next = shift_reg[31:28];
        shift_next = {shift_reg[27:0], 4'h0};
        nib_next = nib_reg - 4'h1;
        if (nib_reg == 4'h1) begin
          tr_next = TR_IDLE;
          for (int s = 2; s >= 0; s--) begin
            if (s[1:0] > seg_reg && seg_on(rec_reg, cfg_reg, s[1:0])) begin
              seg_next = s[1:0];
              tr_next = TR_MARK;
            end
          end
        end
      end
    endcase
    ready_next = (tr_next == TR_IDLE) && !(tr_reg == TR_IDLE && TRACE_VALID && ready_reg);
    attr_next = CORE_ATTR;
    if (remap) begin
      attr_next.tt = emu_debug_pkg::TT_REMAP;
      attr_next.tm = ACC_IS_FETCH ? emu_debug_pkg::TM_REMAP_FETCH : emu_debug_pkg::TM_REMAP_DATA;
    end
    cdis_next = remap;
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      emu_reg <= 1'b0;
      flag_reg <= 1'b0;
      hold_reg <= 3'h0;
      exit_reg <= 1'b0;
      pst_reg <= emu_debug_pkg::PST_IDLE;
      tr_reg <= TR_IDLE;
      rec_reg <= '0;
      seg_reg <= 2'h0;
      nib_reg <= 4'h0;
      shift_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
      attr_reg <= '0;
      cdis_reg <= 1'b0;
    end else begin
      emu_reg <= emu_next;
      flag_reg <= flag_next;
      hold_reg <= hold_next;
      exit_reg <= exit_next;
      pst_reg <= pst_next;
      tr_reg <= tr_next;
      rec_reg <= rec_next;
      seg_reg <= seg_next;
      nib_reg <= nib_next;
      shift_reg <= shift_next;
      ready_reg <= ready_next;
      attr_reg <= attr_next;
      cdis_reg <= cdis_next;
    end
  end

  // local bus sharing with debug commands
  always_comb begin
    arb_next = arb_reg;
    acc_next = 1'b0;
    ref_next = 1'b0;
    if (CMD_VALID) begin
      ref_next = CMD_REG_ACCESS && !CORE_HALTED;
      acc_next = !ref_next;
    end
    unique case (arb_reg)
      ARB_CORE: begin
        if (DBG_BUS_REQ) begin
          arb_next = ARB_DRAIN;
        end
      end
      ARB_DRAIN: begin
        if (CORE_BUS_IDLE) begin
          arb_next = ARB_DEBUG;
        end
      end
      ARB_DEBUG: begin
        if (DBG_BUS_DONE) begin
          arb_next = ARB_CORE;
        end
      end
    endcase
    // stall and grant registered so both leave straight from flops
    share_next = {arb_next != ARB_CORE, arb_next == ARB_DEBUG};
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      arb_reg <= ARB_CORE;
      share_reg <= 2'h0;
      acc_reg <= 1'b0;
      ref_reg <= 1'b0;
    end else begin
      arb_reg <= arb_next;
      share_reg <= share_next;
      acc_reg <= acc_next;
      ref_reg <= ref_next;
    end
  end

  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign EMU_MODE = emu_reg;
  assign FRAME_FAULT_WORD = {14'h0000, flag_reg, 17'h0_0000};
  assign MEM_ATTR = attr_reg;
  assign CACHE_SRAM_DISABLE = cdis_reg;
  assign CMD_ACCEPT = acc_reg;
  assign CMD_REFUSE = ref_reg;
  assign FETCH_STALL = share_reg[1];
  assign DBG_BUS_GRANT = share_reg[0];
  assign TRACE_READY = ready_reg;
  assign STATUS_TRACE = pst_reg;
endmodule : emu_debug_core
`default_nettype wire

// *** bench/emu_debug_asserts.sv ***
// port checks for the emulator-mode and trace block
`timescale 1ns/1ps
`default_nettype none
module emu_debug_asserts (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // mode events
  input wire logic DEBUG_EXC_START,
  input wire logic RTE_EXEC,
  input wire logic RTE_STACKED_FLAG,
  input wire logic EMU_MODE,
  input wire logic [3:0] STATUS_TRACE,
  // memory attributes
  input wire logic ACC_IS_FETCH,
  input wire emu_debug_pkg::bus_attr_s MEM_ATTR,
  input wire logic CACHE_SRAM_DISABLE,
  // commands and bus share
  input wire logic CMD_VALID,
  input wire logic CMD_REG_ACCESS,
  input wire logic CORE_HALTED,
  input wire logic CMD_ACCEPT,
  input wire logic CMD_REFUSE,
  input wire logic DBG_BUS_DONE,
  input wire logic FETCH_STALL,
  input wire logic DBG_BUS_GRANT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  sequence entry_s;
    (STATUS_TRACE == 4'hD) [*3];
  endsequence
  sequence leave_s;
    RTE_EXEC && !RTE_STACKED_FLAG && EMU_MODE && !DEBUG_EXC_START;
  endsequence
  sequence exit_s;
    ##[1:4] (STATUS_TRACE == 4'h7);
  endsequence
  entry_hold_a: assert property (DEBUG_EXC_START |=> entry_s)
    else $error("entry code not held");
  debug_entry_a: assert property (DEBUG_EXC_START |=> EMU_MODE)
    else $error("debug entry missed");
  rte_leave_a: assert property (leave_s |=> !EMU_MODE)
    else $error("mode kept after return");
  exit_code_a: assert property (leave_s |-> exit_s)
    else $error("exit code missing");
  stack_reload_a: assert property (RTE_EXEC && RTE_STACKED_FLAG |=> EMU_MODE)
    else $error("stacked flag not reloaded");
  cache_off_a: assert property (!EMU_MODE |=> !CACHE_SRAM_DISABLE)
    else $error("cache disabled outside mode");
  remap_attr_a: assert property (CACHE_SRAM_DISABLE |->
    MEM_ATTR == {2'h2, $past(ACC_IS_FETCH) ? 3'h6 : 3'h5})
    else $error("remap attributes wrong");
  cmd_refuse_a: assert property (CMD_VALID && CMD_REG_ACCESS && !CORE_HALTED
    |=> CMD_REFUSE && !CMD_ACCEPT)
    else $error("register command not refused");
  cmd_accept_a: assert property (CMD_VALID && !(CMD_REG_ACCESS && !CORE_HALTED)
    |=> CMD_ACCEPT && !CMD_REFUSE)
    else $error("command not accepted");
  bus_grant_a: assert property ($rose(DBG_BUS_GRANT) |-> FETCH_STALL && $past(FETCH_STALL))
    else $error("grant without prior stall");
  bus_release_a: assert property (DBG_BUS_DONE |=> !DBG_BUS_GRANT && !FETCH_STALL)
    else $error("bus not reclaimed");
endmodule : emu_debug_asserts
`default_nettype wire

// *** bench/dev_host_model.sv ***
// development system model: debug commands and memory bus requests
`timescale 1ns/1ps
`default_nettype none
module dev_host_model (
  // clock
  input wire logic clk,
  // commands
  output logic cmd_valid,
  output logic cmd_reg,
  // bus share
  output logic bus_req,
  output logic bus_done,
  input wire logic bus_grant
);
  // outputs start idle: no command, no bus request and no bus done
  initial begin
    cmd_valid = 1'b0;
    cmd_reg = 1'b1;
    bus_req = 1'b0;
    bus_done = 1'b0;
  end
  // register commands while running only when the bench asks
  task send(input logic reg_acc);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_reg <= reg_acc;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_reg <= ~reg_acc;
    #1;
  endtask : send
  task mem(output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    bus_req <= 1'b1;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      ok = bus_grant;
    end
    if (ok) begin
      bus_done <= 1'b1;
      @(posedge clk);
    end
    bus_req <= 1'b0;
    bus_done <= 1'b0;
  endtask : mem
endmodule : dev_host_model
`default_nettype wire

// *** bench/tb_emu_debug_core.sv ***
// testbench for the emulator-mode and trace block
`timescale 1ns/1ps
`default_nettype none
module tb_emu_debug_core;
  logic CLK_SYS, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, RTE_STACKED_FLAG, EMU_MODE;
  logic ACC_IS_FETCH, CACHE_SRAM_DISABLE, CMD_VALID, CMD_REG_ACCESS, CORE_HALTED;
  logic CMD_ACCEPT, CMD_REFUSE, DBG_BUS_REQ, CORE_BUS_IDLE, DBG_BUS_DONE, FETCH_STALL;
  logic DBG_BUS_GRANT, TRACE_VALID, TRACE_READY;
  logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE, STATUS_TRACE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, FRAME_FAULT_WORD, rd;
  logic [4:0] ev;
  emu_debug_pkg::bus_attr_s CORE_ATTR, MEM_ATTR;
  emu_debug_pkg::trace_rec_s TRACE_REC, rec;
  logic [3:0] exq[$];
  int fail_count = 0;
  int samples_checked = 0;
  bit ok;
  emu_debug_core #(.ADDR_W(4)) u_dut (.CLK_SYS, .RESETN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .RESET_PROC_START(ev[4]), .DEBUG_EXC_START(ev[3]), .TRACE_EXC_START(ev[2]),
    .OTHER_EXC_START(ev[1]), .RTE_EXEC(ev[0]), .RTE_STACKED_FLAG, .EMU_MODE,
    .FRAME_FAULT_WORD, .ACC_IS_FETCH, .CORE_ATTR, .MEM_ATTR, .CACHE_SRAM_DISABLE, .CMD_VALID,
    .CMD_REG_ACCESS, .CORE_HALTED, .CMD_ACCEPT, .CMD_REFUSE, .DBG_BUS_REQ, .CORE_BUS_IDLE,
    .DBG_BUS_DONE, .FETCH_STALL, .DBG_BUS_GRANT, .TRACE_VALID, .TRACE_REC, .TRACE_READY,
    .STATUS_TRACE);
  dev_host_model u_host (.clk(CLK_SYS), .cmd_valid(CMD_VALID), .cmd_reg(CMD_REG_ACCESS),
    .bus_req(DBG_BUS_REQ), .bus_done(DBG_BUS_DONE), .bus_grant(DBG_BUS_GRANT));
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= b;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK_SYS);
      if (!AVS_WAITREQUEST) break;
    end
    if (n == 20) begin
      fail_count++;
      final_report();
    end
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  // one event pulse, after any earlier status code has drained
  task evp(input logic [4:0] v, input logic f);
    repeat (5) @(posedge CLK_SYS);
    ev <= v;
    RTE_STACKED_FLAG <= f;
    @(posedge CLK_SYS);
    ev <= 5'h00;
    RTE_STACKED_FLAG <= ~f;
    #1;
  endtask : evp
  task seg(input logic [3:0] mk, input logic [31:0] d, input int nb);
    exq.push_back(mk);
    for (int i = nb * 2 - 1; i >= 0; i--) exq.push_back(d[i*4 +: 4]);
  endtask : seg
  task tr(input logic [31:0] cfg);
    int n;
    bus(1'b1, 4'h0, cfg, 4'hF);
    @(posedge CLK_SYS);
    TRACE_REC <= rec;
    TRACE_VALID <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK_SYS);
      if (TRACE_READY) break;
    end
    if (n == 20) begin
      fail_count++;
      final_report();
    end
    TRACE_VALID <= 1'b0;
    TRACE_REC <= ~rec;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK_SYS);
      #1;
      if (STATUS_TRACE !== 4'h0) break;
    end
    if (n == 20) begin
      fail_count++;
      final_report();
    end
    foreach (exq[i]) begin
      chk({28'h0, STATUS_TRACE}, {28'h0, exq[i]});
      @(posedge CLK_SYS);
      #1;
    end
    exq.delete();
  endtask : tr
  task final_report;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    RESETN = 1'b0;
    {AVS_READ, AVS_WRITE, ACC_IS_FETCH, CORE_HALTED, CORE_BUS_IDLE, TRACE_VALID} = '0;
    {AVS_ADDRESS, AVS_BYTEENABLE, AVS_WRITEDATA, ev, RTE_STACKED_FLAG} = '0;
    CORE_ATTR = {2'h1, 3'h3};
    TRACE_REC = '0;
    repeat (16) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk(rd, 32'h0);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
    bus(1'b1, 4'h0, 32'h0, 4'hE);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk(rd, 32'h1F);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    chk(rd, 32'h0);
    bus(1'b1, 4'h0, 32'h1, 4'hF);
    chk(EMU_MODE, 1'b0);
    evp(5'h10, 1'b0);
    chk(EMU_MODE, 1'b1);
    evp(5'h01, 1'b0);
    chk({EMU_MODE, STATUS_TRACE}, 5'h07);
    bus(1'b1, 4'h0, 32'h4, 4'hF);
    evp(5'h08, 1'b0);
    chk({EMU_MODE, STATUS_TRACE}, 5'h1D);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    chk(rd, 32'h1);
    @(posedge CLK_SYS);
    ACC_IS_FETCH <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({CACHE_SRAM_DISABLE, MEM_ATTR}, {1'b1, 2'h2, 3'h6});
    @(posedge CLK_SYS);
    ACC_IS_FETCH <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk(MEM_ATTR, {2'h2, 3'h5});
    evp(5'h02, 1'b0);
    chk({EMU_MODE, FRAME_FAULT_WORD[17]}, 2'b01);
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({CACHE_SRAM_DISABLE, MEM_ATTR}, {1'b0, 2'h1, 3'h3});
    evp(5'h01, 1'b1);
    chk({EMU_MODE, STATUS_TRACE}, 5'h1D);
    evp(5'h01, 1'b0);
    evp(5'h02, 1'b0);
    chk(FRAME_FAULT_WORD[17], 1'b0);
    bus(1'b1, 4'h0, 32'h2, 4'hF);
    evp(5'h04, 1'b0);
    chk(EMU_MODE, 1'b1);
    evp(5'h01, 1'b0);
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    evp(5'h04, 1'b0);
    chk(EMU_MODE, 1'b0);
    u_host.send(1'b1);
    chk({CMD_ACCEPT, CMD_REFUSE}, 2'b01);
    u_host.send(1'b0);
    chk({CMD_ACCEPT, CMD_REFUSE}, 2'b10);
    @(posedge CLK_SYS);
    CORE_HALTED <= 1'b1;
    u_host.send(1'b1);
    chk({CMD_ACCEPT, CMD_REFUSE}, 2'b10);
    fork
      u_host.mem(ok);
      begin
        repeat (6) @(posedge CLK_SYS);
        #1;
        chk({FETCH_STALL, DBG_BUS_GRANT}, 2'b10);
        @(posedge CLK_SYS);
        CORE_BUS_IDLE <= 1'b1;
      end
    join
    #1;
    chk({ok, FETCH_STALL, DBG_BUS_GRANT}, 3'b100);
    if (!ok) final_report();
    rec = '{default: '0, rd_valid: 1'b1, rd_data: 32'hA5, wr_valid: 1'b1, wr_data: 32'h5A};
    exq = {4'h1};
    tr(32'h0);
    exq = {4'h1};
    seg(4'h8, 32'hA5, 1);
    seg(4'h8, 32'h5A, 1);
    tr(32'h18);
    rec.wr_size = 2'h1;
    rec.wr_data = 32'h1234;
    exq = {4'h1};
    seg(4'h9, 32'h1234, 2);
    tr(32'h10);
    rec = '{default: '0, rd_valid: 1'b1, rd_size: 2'h2, rd_data: 32'h89AB_CDEF,
      wr_valid: 1'b1, wr_size: 2'h2, wr_data: 32'h0123_4567};
    exq = {4'h1};
    seg(4'hB, 32'h89AB_CDEF, 4);
    seg(4'hB, 32'h0123_4567, 4);
    tr(32'h18);
    for (int k = 0; k < 3; k++) begin
      rec = '{default: '0, cof: 1'b1, cond: (k < 2), taken: (k > 0)};
      exq = {(k > 0) ? 4'h5 : 4'h1};
      tr(32'h0);
    end
    for (int k = 1; k < 4; k++) begin
      rec = '{default: '0, cof: 1'b1, taken: 1'b1, tgt_valid: 1'b1, tgt_addr: 32'h00C0_FFEE};
      exq = {4'h5};
      seg(4'h8 + k[3:0], 32'h00C0_FFEE, k + 1);
      tr({22'h0, k[1:0], 8'h0});
    end
    rec = '{default: '0, cof: 1'b1, taken: 1'b1, wr_valid: 1'b1, wr_size: 2'h2,
      wr_data: 32'hDEAD_BEEF};
    exq = {4'h5};
    seg(4'hB, 32'hDEAD_BEEF, 4);
    tr(32'h10);
    final_report();
  end
endmodule : tb_emu_debug_core
bind emu_debug_core emu_debug_asserts u_chk (.CLK_SYS, .RESETN, .DEBUG_EXC_START, .RTE_EXEC,
  .RTE_STACKED_FLAG, .EMU_MODE, .STATUS_TRACE, .ACC_IS_FETCH, .MEM_ATTR, .CACHE_SRAM_DISABLE,
  .CMD_VALID, .CMD_REG_ACCESS, .CORE_HALTED, .CMD_ACCEPT, .CMD_REFUSE, .DBG_BUS_DONE,
  .FETCH_STALL, .DBG_BUS_GRANT);
`default_nettype wire
